// *** rtl/mfc_consts.vh ***
`ifndef MFC_CONSTS_VH
`define MFC_CONSTS_VH
// configuration dword offsets (byte addresses)
`define MFC_OFS_ID 8'h00
`define MFC_OFS_CMD 8'h04
`define MFC_OFS_CLASS 8'h08
`define MFC_OFS_HDR 8'h0c
`define MFC_OFS_IOBAR 8'h10
`define MFC_OFS_MEMBAR 8'h14
`define MFC_OFS_CIS 8'h28
`define MFC_OFS_SUBSYS 8'h2c
`define MFC_OFS_CAPPTR 8'h34
`define MFC_OFS_INT 8'h3c
`define MFC_OFS_PMCAP 8'hdc
`define MFC_OFS_PMCSR 8'he0
// command word
`define MFC_CMD_WMASK 16'h0143
`define MFC_CMD_IO 0
`define MFC_CMD_MEM 1
// status word
`define MFC_STS_FIXED 16'h0210
`define MFC_STS_PERR 15
`define MFC_STS_SERR 14
// class and revision
`define MFC_BASE_CLASS 8'h07
`define MFC_SUB_CLASS 8'h00
`define MFC_HDR_KIND 8'h80
// base address windows
`define MFC_IOBAR_MASK 32'hfffffff8
`define MFC_IOBAR_LOW 32'h00000001
`define MFC_MEMBAR_MASK 32'hfffffe00
`define MFC_CIS_PTR 32'h00000102
`define MFC_CIS_AREA 9'h100
// capability
`define MFC_CAP_PTR 8'hdc
`define MFC_CAP_ID 8'h01
`define MFC_PMC_AUX 16'hfe31
`define MFC_PMC_NOAUX 16'h7e21
`define MFC_INT_PIN 8'h01
// power control/status fields
`define MFC_PM_STATE_LO 0
`define MFC_PM_PME_EN 8
`define MFC_PM_SEL_LO 9
`define MFC_PM_PME_ST 15
`define MFC_PM_WMASK 16'h1f03
// data register table
`define MFC_SCALE_PWR 2'h2
`define MFC_SCALE_NONE 2'h0
`define MFC_NONE_ANSWER 32'hffffffff
`endif

// *** rtl/mfc_power_data.v ***
`timescale 1ns/1ps
`default_nettype none
`include "mfc_consts.vh"
// picks the reported power byte and its scale for a data select value
module mfc_power_data
(
  input wire [3:0] sel,
  input wire [63:0] nv_power,
  output reg [7:0] data,
  output reg [1:0] scale
);
  always @*
  begin
    if (!sel[3])
    begin
      data = nv_power[{sel[2:0], 3'h0} +: 8];
      scale = `MFC_SCALE_PWR;
    end
    else
    begin
      data = 8'h00;
      scale = `MFC_SCALE_NONE;
    end
  end
endmodule // mfc_power_data
`default_nettype wire

// *** rtl/mfc_config_space.v ***
`timescale 1ns/1ps
`default_nettype none
`include "mfc_consts.vh"
// How it works
// - command word 16 bits; bits 8,6,1,0 writable, reset 0; others zero.
// - status word: bits 15,14 writable, 10:9 read 01, bit 4 reads 1.
// - status word returns to defaults on bus reset.
// - class word read-only: 07h, 00h, program interface, revision.
// - program interface and revision come from nonvolatile word FEh.
// - header kind byte fixed at 80h, multifunction.
// - I/O window base requests 8 bytes; low bits fixed.
// - memory window base requests 512 bytes; control plus card info.
// - card info pointer reads offset 0100h above control, space 2h.
// - card info content in the window comes from nonvolatile memory.
// - subsystem vendor mirrors LAN nonvolatile value.
// - subsystem ident mirrors LAN nonvolatile value.
// - capability pointer fixed at DCh.
// - interrupt register mirrors LAN one and requests an interrupt.
// - modem and LAN interrupts share one output.
// - power capabilities FE31h with aux supply, 7E21h without.
// - power control/status laid out and behaving like the LAN one.
// - data register: selects 0-7 nonvolatile values scale 2, else 0.
// - modem enabled and boot not disabled: both functions active.
// - boot enable bit selects boot ROM or modem on shared interface.
// - LAN answers as function zero, modem as function one.
// - modem function exists only when nonvolatile setup enables it.
module mfc_config_space
(
  input wire clk_sys,
  input wire rst,
  // configuration access from the host bus target
  input wire cfg_req,
  input wire cfg_wr,
  input wire [2:0] cfg_func,
  input wire [7:0] cfg_addr,
  input wire [3:0] cfg_be,
  input wire [31:0] cfg_wdata,
  output reg cfg_ack_q,
  output reg [31:0] cfg_rdata_q,
  // target address decode for the modem windows
  input wire tgt_io_req,
  input wire tgt_mem_req,
  input wire [31:0] tgt_addr,
  output reg io_hit_q,
  output reg mem_hit_q,
  output reg cis_hit_q,
  // nonvolatile loaded values
  input wire [31:0] nv_dev_vend,
  input wire [15:0] nv_pif_rev,
  input wire [15:0] nv_subsys_vendor,
  input wire [15:0] nv_subsys_ident,
  input wire [63:0] nv_power,
  input wire modem_function_enable_bit,
  input wire boot_rom_disable_bit,
  // LAN side values
  input wire [7:0] lan_int_line,
  input wire boot_rom_window_base,
  input wire lan_irq,
  input wire modem_irq,
  // events and pins
  input wire parity_err_evt,
  input wire sys_err_evt,
  input wire pme_evt,
  input wire aux_power_pin,
  output reg int_n_q,
  output reg flash_modem_chip_select_q,
  output reg boot_rom_active_q,
  output reg modem_active_q,
  output reg [1:0] power_state_q
);
  localparam ST_IDLE = 2'b01;
  localparam ST_ANSWER = 2'b10;

  reg [1:0] state_q;
  reg [15:0] cmd_q;
  reg [15:0] sts_q;
  reg [31:0] iobar_q;
  reg [31:0] membar_q;
  reg [15:0] pmcsr_q;
  reg aux_meta_q;
  reg aux_q;
  reg [31:0] rd_d;
  reg hit_d;
  wire present;
  wire wr_ok;
  wire [7:0] pwr_data;
  wire [1:0] pwr_scale;
  wire [15:0] sts_wr;
  wire [15:0] pm_wr;
  // merged write values, cut to the register widths below
  wire [31:0] cmd_new;
  wire [31:0] pm_new;

  // merges a write under byte enables
  function [31:0] bmerge;
    input [31:0] old;
    input [31:0] new_val;
    input [3:0] be;
    integer i;
    begin
      bmerge = old;
      for (i = 0; i < 4; i = i + 1)
        if (be[i])
          bmerge[i*8 +: 8] = new_val[i*8 +: 8];
    end
  endfunction

  assign present = modem_function_enable_bit;
  // function one only; LAN logic owns function zero
  assign wr_ok = cfg_req && cfg_wr && present &&
    (cfg_func == 3'h1) && (state_q == ST_IDLE);
  // write-one masks for the clearable bits, status from byte lane three, power status from byte lane one
  assign sts_wr = (wr_ok && cfg_addr == `MFC_OFS_CMD && cfg_be[3]) ?
    cfg_wdata[31:16] : 16'h0000;
  assign pm_wr = (wr_ok && cfg_addr == `MFC_OFS_PMCSR && cfg_be[1]) ?
    cfg_wdata[15:0] : 16'h0000;
  assign cmd_new = bmerge({16'h0000, cmd_q}, cfg_wdata, cfg_be) &
    {16'h0000, `MFC_CMD_WMASK};
  assign pm_new = bmerge({16'h0000, pmcsr_q}, cfg_wdata, cfg_be) &
    {16'h0000, `MFC_PM_WMASK};

  mfc_power_data u_power_data
  (
    .sel(pmcsr_q[`MFC_PM_SEL_LO +: 4]),
    .nv_power(nv_power),
    .data(pwr_data),
    .scale(pwr_scale)
  );

  // read mux
  always @*
  begin
    rd_d = 32'h00000000;
    hit_d = 1'b1;
    case (cfg_addr)
      `MFC_OFS_ID:
        rd_d = nv_dev_vend;
      `MFC_OFS_CMD:
        rd_d = {sts_q, cmd_q};
      `MFC_OFS_CLASS:
        rd_d = {`MFC_BASE_CLASS, `MFC_SUB_CLASS, nv_pif_rev};
      `MFC_OFS_HDR:
        rd_d = {8'h00, `MFC_HDR_KIND, 16'h0000};
      `MFC_OFS_IOBAR:
        rd_d = iobar_q;
      `MFC_OFS_MEMBAR:
        rd_d = membar_q;
      `MFC_OFS_CIS:
        rd_d = `MFC_CIS_PTR;
      `MFC_OFS_SUBSYS:
        rd_d = {nv_subsys_ident, nv_subsys_vendor};
      `MFC_OFS_CAPPTR:
        rd_d = {24'h000000, `MFC_CAP_PTR};
      `MFC_OFS_INT:
        rd_d = {16'h0000, `MFC_INT_PIN, lan_int_line};
      `MFC_OFS_PMCAP:
        rd_d = {(aux_q ? `MFC_PMC_AUX : `MFC_PMC_NOAUX),
          8'h00, `MFC_CAP_ID};
      `MFC_OFS_PMCSR:
        rd_d = {8'h00, pwr_data,
          pmcsr_q[15], pwr_scale, pmcsr_q[12:0]};
      default:
        hit_d = 1'b0;
    endcase
  end

  // access sequencer: one answer per request
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      state_q <= ST_IDLE;
      cfg_ack_q <= 1'b0;
      cfg_rdata_q <= 32'h00000000;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          if (cfg_req)
          begin
            state_q <= ST_ANSWER;
            cfg_ack_q <= 1'b1;
            if (!present || cfg_func != 3'h1)
              cfg_rdata_q <= `MFC_NONE_ANSWER;
            else if (cfg_wr || !hit_d)
              cfg_rdata_q <= 32'h00000000;
            else
              cfg_rdata_q <= rd_d;
          end
        end
        ST_ANSWER:
        begin
          state_q <= ST_IDLE;
          cfg_ack_q <= 1'b0;
        end
        default:
        begin
          state_q <= ST_IDLE;
          cfg_ack_q <= 1'b0;
        end
      endcase
    end
  end

  // writable registers; read-only fields have no write path
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      cmd_q <= 16'h0000;
      sts_q <= `MFC_STS_FIXED;
      iobar_q <= `MFC_IOBAR_LOW;
      membar_q <= 32'h00000000;
      pmcsr_q <= 16'h0000;
    end
    else
    begin
      if (wr_ok && cfg_addr == `MFC_OFS_CMD)
        cmd_q <= cmd_new[15:0];
      if (wr_ok && cfg_addr == `MFC_OFS_IOBAR)
        iobar_q <= (bmerge(iobar_q, cfg_wdata, cfg_be) & `MFC_IOBAR_MASK)
          | `MFC_IOBAR_LOW;
      if (wr_ok && cfg_addr == `MFC_OFS_MEMBAR)
        membar_q <= bmerge(membar_q, cfg_wdata, cfg_be)
          & `MFC_MEMBAR_MASK;
      // error flags: new event wins over a write-one clear
      sts_q[`MFC_STS_PERR] <= parity_err_evt |
        (sts_q[`MFC_STS_PERR] & ~sts_wr[`MFC_STS_PERR]);
      sts_q[`MFC_STS_SERR] <= sys_err_evt |
        (sts_q[`MFC_STS_SERR] & ~sts_wr[`MFC_STS_SERR]);
      // power control: state, enable, select writable; status sticky
      if (wr_ok && cfg_addr == `MFC_OFS_PMCSR)
        pmcsr_q[12:0] <= pm_new[12:0];
      pmcsr_q[`MFC_PM_PME_ST] <= (pme_evt & pmcsr_q[`MFC_PM_PME_EN]) |
        (pmcsr_q[`MFC_PM_PME_ST] & ~pm_wr[`MFC_PM_PME_ST]);
    end
  end

  // aux supply pin is asynchronous
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      aux_meta_q <= 1'b0;
      aux_q <= 1'b0;
    end
    else
    begin
      aux_meta_q <= aux_power_pin;
      aux_q <= aux_meta_q;
    end
  end

  // window decode and shared interface steering
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      io_hit_q <= 1'b0;
      mem_hit_q <= 1'b0;
      cis_hit_q <= 1'b0;
      int_n_q <= 1'b1;
      flash_modem_chip_select_q <= 1'b0;
      boot_rom_active_q <= 1'b0;
      modem_active_q <= 1'b0;
      power_state_q <= 2'h0;
    end
    else
    begin
      io_hit_q <= present && tgt_io_req && cmd_q[`MFC_CMD_IO] &&
        ((tgt_addr & `MFC_IOBAR_MASK) ==
        (iobar_q & `MFC_IOBAR_MASK));
      mem_hit_q <= present && tgt_mem_req && cmd_q[`MFC_CMD_MEM] &&
        ((tgt_addr & `MFC_MEMBAR_MASK) == membar_q);
      // upper half of the window holds card info from nonvolatile memory
      cis_hit_q <= present && tgt_mem_req && cmd_q[`MFC_CMD_MEM] &&
        ((tgt_addr & `MFC_MEMBAR_MASK) == membar_q) &&
        (tgt_addr[8:0] >= `MFC_CIS_AREA);
      int_n_q <= ~(lan_irq | (present & modem_irq));
      modem_active_q <= present;
      boot_rom_active_q <= ~boot_rom_disable_bit;
      // boot enable set: boot ROM owns the shared select
      flash_modem_chip_select_q <= ~boot_rom_disable_bit &
        boot_rom_window_base;
      power_state_q <= pmcsr_q[`MFC_PM_STATE_LO +: 2];
    end
  end
endmodule // mfc_config_space
`default_nettype wire

// *** test/mfc_config_space_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module mfc_config_space_props
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic cfg_req,
  input wire logic cfg_wr,
  input wire logic [2:0] cfg_func,
  input wire logic [7:0] cfg_addr,
  input wire logic cfg_ack_q,
  input wire logic [31:0] cfg_rdata_q,
  input wire logic tgt_io_req,
  input wire logic [31:0] tgt_addr,
  input wire logic io_hit_q,
  input wire logic mem_hit_q,
  input wire logic cis_hit_q,
  input wire logic [15:0] nv_pif_rev,
  input wire logic modem_function_enable_bit,
  input wire logic boot_rom_disable_bit,
  input wire logic boot_rom_window_base,
  input wire logic lan_irq,
  input wire logic modem_irq,
  input wire logic int_n_q,
  input wire logic flash_modem_chip_select_q,
  input wire logic boot_rom_active_q,
  input wire logic modem_active_q
);
  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  wire rq = cfg_req && !cfg_wr && !cfg_ack_q;
  wire rd1 = rq && cfg_func == 3'h1 && modem_function_enable_bit;
  property p_func;
    rq && cfg_func != 3'h1 |=> cfg_ack_q && cfg_rdata_q == 32'hffffffff;
  endproperty
  a_func: assert property (p_func)
    else $error("other function read not all ones");
  property p_absent;
    rq && !modem_function_enable_bit |=> cfg_rdata_q == 32'hffffffff;
  endproperty
  a_absent: assert property (p_absent)
    else $error("absent modem read not all ones");
  property p_hdr;
    rd1 && cfg_addr == 8'h0c |=> cfg_rdata_q == 32'h00800000;
  endproperty
  a_hdr: assert property (p_hdr)
    else $error("header kind wrong");
  property p_cis;
    rd1 && cfg_addr == 8'h28 |=> cfg_rdata_q == 32'h00000102;
  endproperty
  a_cis: assert property (p_cis)
    else $error("card info pointer wrong");
  property p_cap;
    rd1 && cfg_addr == 8'h34 |=> cfg_rdata_q == 32'h000000dc;
  endproperty
  a_cap: assert property (p_cap)
    else $error("capability pointer wrong");
  property p_class;
    rd1 && cfg_addr == 8'h08 |=> cfg_rdata_q == {16'h0700, $past(nv_pif_rev)};
  endproperty
  a_class: assert property (p_class)
    else $error("class word wrong");
  property p_int;
    1'b1 |=> int_n_q == !($past(lan_irq) ||
      ($past(modem_irq) && $past(modem_function_enable_bit)));
  endproperty
  a_int: assert property (p_int)
    else $error("shared interrupt wrong");
  property p_hit;
    io_hit_q |-> $past(tgt_io_req);
  endproperty
  a_hit: assert property (p_hit)
    else $error("io hit without request");
  property p_cishit;
    cis_hit_q |-> mem_hit_q && $past(tgt_addr[8]);
  endproperty
  a_cishit: assert property (p_cishit)
    else $error("card info hit below its area");
  property p_sel;
    !$past(rst) && $stable(boot_rom_window_base) && $stable(boot_rom_disable_bit)
      |=> flash_modem_chip_select_q ==
      ($past(boot_rom_window_base) && !$past(boot_rom_disable_bit));
  endproperty
  a_sel: assert property (p_sel)
    else $error("shared interface routing wrong");
  property p_act;
    !$past(rst) && modem_function_enable_bit && !boot_rom_disable_bit &&
      $stable(modem_function_enable_bit) && $stable(boot_rom_disable_bit)
      |=> modem_active_q && boot_rom_active_q;
  endproperty
  a_act: assert property (p_act)
    else $error("modem and boot rom not both active");
endmodule // mfc_config_space_props
bind mfc_config_space mfc_config_space_props u_props (.clk_sys, .rst,
  .cfg_req, .cfg_wr, .cfg_func, .cfg_addr, .cfg_ack_q, .cfg_rdata_q,
  .tgt_io_req, .tgt_addr, .io_hit_q, .mem_hit_q, .cis_hit_q, .nv_pif_rev,
  .modem_function_enable_bit, .boot_rom_disable_bit, .boot_rom_window_base,
  .lan_irq, .modem_irq, .int_n_q, .flash_modem_chip_select_q,
  .boot_rom_active_q, .modem_active_q);
`default_nettype wire

// *** test/mfc_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// sole master of the config lines, no companion on the bus
module mfc_host_model
(
  input wire logic clk_sys,
  input wire logic cfg_ack_q,
  input wire logic [31:0] cfg_rdata_q,
  output logic cfg_req = 1'b0,
  output logic cfg_wr = 1'b0,
  output logic [2:0] cfg_func = 3'h0,
  output logic [7:0] cfg_addr = 8'h0,
  output logic [3:0] cfg_be = 4'h0,
  output logic [31:0] cfg_wdata = 32'h0
);
  task acc(input logic w, input logic [2:0] f, input logic [7:0] a,
    input logic [3:0] b, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_sys);
    cfg_req <= 1'b1;
    cfg_wr <= w;
    cfg_func <= f;
    cfg_addr <= a;
    cfg_be <= b;
    cfg_wdata <= d;
    do
    begin
      @(posedge clk_sys);
      n++;
    end while (cfg_ack_q !== 1'b1 && n < 8);
    q = cfg_rdata_q;
    cfg_req <= 1'b0;
    // released address and data lines carry junk, not the last value
    cfg_addr <= ~a;
    cfg_wdata <= ~d;
  endtask
endmodule // mfc_host_model
`default_nettype wire

// *** test/tb_modem_function_config_space.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_modem_function_config_space;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic cfg_req, cfg_wr, cfg_ack_q, io_hit_q, mem_hit_q, cis_hit_q;
  logic tgt_io_req = 0, tgt_mem_req = 0, modem_function_enable_bit = 1;
  logic boot_rom_disable_bit = 0, boot_rom_window_base = 0, lan_irq = 0;
  logic modem_irq = 0, parity_err_evt = 0, sys_err_evt = 0, pme_evt = 0;
  logic aux_power_pin = 1, int_n_q, flash_modem_chip_select_q;
  logic boot_rom_active_q, modem_active_q;
  logic [1:0] power_state_q;
  logic [2:0] cfg_func;
  logic [3:0] cfg_be;
  logic [7:0] cfg_addr, lan_int_line = 8'h0b;
  logic [31:0] cfg_wdata, cfg_rdata_q, q, tgt_addr = 0;
  logic [31:0] nv_dev_vend = 32'h5a5a1234; // arbitrary id value
  logic [15:0] nv_pif_rev = 16'h0203, nv_subsys_vendor = 16'h1111;
  logic [15:0] nv_subsys_ident = 16'h2222;
  logic [63:0] nv_power = 64'h8877665544332211;
  int err_count = 0, tests_run = 0, cyc = 0;
  always #10 clk_sys = ~clk_sys;
  mfc_config_space uut (.clk_sys, .rst, .cfg_req, .cfg_wr, .cfg_func,
    .cfg_addr, .cfg_be, .cfg_wdata, .cfg_ack_q, .cfg_rdata_q, .tgt_io_req,
    .tgt_mem_req, .tgt_addr, .io_hit_q, .mem_hit_q, .cis_hit_q, .nv_dev_vend,
    .nv_pif_rev, .nv_subsys_vendor, .nv_subsys_ident, .nv_power,
    .modem_function_enable_bit, .boot_rom_disable_bit, .lan_int_line,
    .boot_rom_window_base, .lan_irq, .modem_irq, .parity_err_evt,
    .sys_err_evt, .pme_evt, .aux_power_pin, .int_n_q,
    .flash_modem_chip_select_q, .boot_rom_active_q, .modem_active_q,
    .power_state_q);
  mfc_host_model host (.clk_sys, .cfg_ack_q, .cfg_rdata_q, .cfg_req,
    .cfg_wr, .cfg_func, .cfg_addr, .cfg_be, .cfg_wdata);
  task test_done;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    host.acc(1'b0, 3'h1, a, 4'hf, 32'h0, q);
    chk($sformatf("cfg %h", a), e, q);
  endtask
  task wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
    host.acc(1'b1, 3'h1, a, b, d, q);
  endtask
  task do_rst;
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
  endtask
  task probe(input logic io, input logic [31:0] a, input logic [2:0] e);
    @(posedge clk_sys);
    tgt_io_req <= io;
    tgt_mem_req <= !io;
    tgt_addr <= a;
    @(posedge clk_sys);
    tgt_io_req <= 1'b0;
    tgt_mem_req <= 1'b0;
    tgt_addr <= ~a;
    #1 chk("window hits", {29'h0, e}, {29'h0, io_hit_q, mem_hit_q, cis_hit_q});
  endtask
  // hang guard, well above the length of the sequence
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      err_count++;
      test_done();
    end
  end
  initial
  begin
    logic [4:0] i;
    do_rst;
    rd(8'h04, 32'h02100000);
    rd(8'h10, 32'h00000001);
    rd(8'h14, 32'h00000000);
    wr(8'h04, 4'hf, 32'hffffffff);
    rd(8'h04, 32'h02100143);
    @(posedge clk_sys);
    parity_err_evt <= 1'b1;
    sys_err_evt <= 1'b1;
    @(posedge clk_sys);
    parity_err_evt <= 1'b0;
    sys_err_evt <= 1'b0;
    rd(8'h04, 32'hc2100143);
    wr(8'h04, 4'h8, 32'h80000000);
    rd(8'h04, 32'h42100143);
    do_rst;
    rd(8'h04, 32'h02100000);
    $display("test command and status done");
    for (int j = 0; j < 8; j++)
      wr(8'h08 + 8'(j) * 8'h04, 4'hf, 32'hffffffff);
    wr(8'h28, 4'hf, 32'hffffffff);
    wr(8'h34, 4'hf, 32'hffffffff);
    rd(8'h00, nv_dev_vend);
    rd(8'h08, {16'h0700, nv_pif_rev});
    rd(8'h0c, 32'h00800000);
    rd(8'h28, 32'h00000102);
    rd(8'h2c, {nv_subsys_ident, nv_subsys_vendor});
    rd(8'h34, 32'h000000dc);
    rd(8'h3c, {16'h0, 8'h01, lan_int_line});
    rd(8'hdc, 32'hfe310001);
    @(posedge clk_sys);
    aux_power_pin <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rd(8'hdc, 32'h7e210001);
    $display("test fixed words done");
    for (i = 0; i < 16; i++)
    begin
      wr(8'he0, 4'h3, {19'h0, i[3:0], 7'h0, 2'h3});
      rd(8'he0, {8'h0, i < 8 ? nv_power[8 * i +: 8] : 8'h0, 1'b0,
        i < 8 ? 2'h2 : 2'h0, i[3:0], 9'h3});
    end
    chk("power state", 32'h3, {30'h0, power_state_q});
    wr(8'he0, 4'h3, 32'h00000100);
    @(posedge clk_sys);
    pme_evt <= 1'b1;
    @(posedge clk_sys);
    pme_evt <= 1'b0;
    rd(8'he0, {8'h0, nv_power[7:0], 16'hc100});
    wr(8'he0, 4'h2, 32'h00008100);
    rd(8'he0, {8'h0, nv_power[7:0], 16'h4100});
    $display("test power done");
    wr(8'h10, 4'hf, 32'h00001000);
    wr(8'h14, 4'hf, 32'h00002000);
    probe(1'b1, 32'h00001004, 3'b000);
    wr(8'h04, 4'h3, 32'h00000003);
    probe(1'b1, 32'h00001004, 3'b100);
    probe(1'b1, 32'h0000100c, 3'b000);
    probe(1'b0, 32'h00002104, 3'b011);
    probe(1'b0, 32'h00002004, 3'b010);
    probe(1'b0, 32'h00003004, 3'b000);
    @(posedge clk_sys);
    modem_irq <= 1'b1;
    boot_rom_window_base <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1 chk("int_n", 32'h0, {31'h0, int_n_q});
    chk("routing", 32'h7, {29'h0, flash_modem_chip_select_q,
      boot_rom_active_q, modem_active_q});
    host.acc(1'b0, 3'h0, 8'h04, 4'hf, 32'h0, q);
    chk("function 0", 32'hffffffff, q);
    @(posedge clk_sys);
    modem_function_enable_bit <= 1'b0;
    rd(8'h04, 32'hffffffff);
    $display("test windows and pins done");
    test_done();
  end
endmodule // tb_modem_function_config_space
`default_nettype wire
